// File: rtl/qrs_defines.svh
// Constants for the burst SRAM port: burst shape and reset values.
`ifndef QRS_DEFINES_SVH
`define QRS_DEFINES_SVH

`define QRS_BEAT_W 2
`define QRS_BEAT_FIRST 2'h0
`define QRS_BEAT_SECOND 2'h1
`define QRS_BEAT_LAST 2'h3
`define QRS_DATA_W 36
`define QRS_LANE_W 9
`define QRS_ADDR_W 17
`define QRS_BIT_CLR 1'h0
`define QRS_BIT_SET 1'h1

`endif

// File: rtl/qrs_pkg.sv
// Types shared by the burst SRAM port modules.
package qrs_pkg;

   // One-hot states of the read burst sequencer.
   typedef enum logic [3:0] {
      QRS_RD_IDLE = 4'h1,
      QRS_RD_WAIT = 4'h2,
      QRS_RD_BURST = 4'h4,
      QRS_RD_HOLD = 4'h8
   } qrs_rd_state_type;

endpackage

// File: rtl/qrs_mem_if.sv
// Interface between the port logic and the storage array.
`timescale 1ns/1ns
interface qrs_mem_if #(
   parameter int DATA_W = 36,
   parameter int LANES = 4,
   parameter int WADDR_W = 19
);
   logic we;
   logic [WADDR_W-1:0] waddr;
   logic [DATA_W-1:0] wdata;
   logic [LANES-1:0] lane_en;
   logic [WADDR_W-1:0] raddr;
   logic [DATA_W-1:0] rdata;

   modport ctl (output we, output waddr, output wdata, output lane_en, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input lane_en, input raddr, output rdata);
endinterface

// File: rtl/qrs_mem.sv
// Storage array: four words per location, per-lane write enables.
`timescale 1ns/1ns
module qrs_mem #(
   parameter int DATA_W = 36,
   parameter int LANE_W = 9,
   parameter int WADDR_W = 19
) (
   input wire logic sys_clk_i,
   qrs_mem_if.mem bus
);
   localparam int LANES = DATA_W / LANE_W;

   // A lane whose enable is low keeps its old contents.
   // Each lane owns its array, so no storage word has more than one writing process.
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_store [0:(1 << WADDR_W)-1];

      always_ff @(posedge sys_clk_i) begin
         if (bus.we && bus.lane_en[g]) begin
            lane_store[bus.waddr] <= bus.wdata[g*LANE_W +: LANE_W];
         end
      end

      assign bus.rdata[g*LANE_W +: LANE_W] = lane_store[bus.raddr];
   end
endmodule

// File: rtl/qrs_port.sv
// Synchronous pin logic of a burst SRAM with split read and write ports.
`timescale 1ns/1ns
`include "qrs_defines.svh"
module qrs_port #(
   parameter int DATA_W = `QRS_DATA_W,
   parameter int LANE_W = `QRS_LANE_W,
   parameter int ADDR_W = `QRS_ADDR_W
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic input_edge_pos_i,
   input wire logic input_edge_neg_i,
   input wire logic read_out_edge_pos_i,
   input wire logic read_out_edge_neg_i,
   input wire logic single_clock_mode_i,
   input wire logic dll_disable_n_i,
   input wire logic write_port_sel_n_i,
   input wire logic read_port_sel_n_i,
   input wire logic [ADDR_W-1:0] word_loc_i,
   input wire logic [DATA_W-1:0] write_in_i,
   input wire logic [DATA_W/LANE_W-1:0] byte_write_sel_n_i,
   output logic [DATA_W-1:0] read_out_o,
   output logic read_out_oe_o,
   output logic echo_strobe_o
);
   localparam int LANES = DATA_W / LANE_W;
   localparam int WADDR_W = ADDR_W + `QRS_BEAT_W;

   // ==========================================================
   // Storage
   // ==========================================================
   qrs_mem_if #(.DATA_W(DATA_W), .LANES(LANES), .WADDR_W(WADDR_W)) mbus ();

   // Each location spans four consecutive words, each split across the per-lane arrays.
   qrs_mem #(.DATA_W(DATA_W), .LANE_W(LANE_W), .WADDR_W(WADDR_W)) u_mem (
      .sys_clk_i(sys_clk_i),
      .bus(mbus.mem)
   );

   // ==========================================================
   // Write port
   // ==========================================================
   logic wr_active_r;
   logic [`QRS_BEAT_W-1:0] wr_beat_r;
   logic [ADDR_W-1:0] wr_addr_r;
   logic wr_start;
   logic wr_beat;

   // A read select on the same edge owns the shared address, so the write does not start on that edge.
   assign wr_start = input_edge_pos_i && !write_port_sel_n_i && read_port_sel_n_i && !wr_active_r;
   assign wr_beat = wr_start || (wr_active_r && (input_edge_pos_i || input_edge_neg_i));

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_active_r <= `QRS_BIT_CLR;
         wr_beat_r <= `QRS_BEAT_FIRST;
      end else if (wr_start) begin
         wr_active_r <= `QRS_BIT_SET;
         wr_beat_r <= `QRS_BEAT_SECOND;
      end else if (wr_beat) begin
         wr_active_r <= (wr_beat_r != `QRS_BEAT_LAST);
         wr_beat_r <= wr_beat_r + `QRS_BEAT_SECOND;
      end
   end

   // The address is only taken when the write port is selected.
   always_ff @(posedge sys_clk_i) begin
      if (wr_start) begin
         wr_addr_r <= word_loc_i;
      end
   end

   assign mbus.we = wr_beat;
   assign mbus.waddr = wr_start ? {word_loc_i, `QRS_BEAT_FIRST} : {wr_addr_r, wr_beat_r};
   assign mbus.wdata = write_in_i;
   // Masks are taken on the very beat they qualify; low selects a lane.
   assign mbus.lane_en = ~byte_write_sel_n_i;

   // ==========================================================
   // Read port
   // ==========================================================
   qrs_pkg::qrs_rd_state_type rd_state_r;
   logic [`QRS_BEAT_W-1:0] rd_beat_r;
   logic [ADDR_W-1:0] rd_addr_r;
   logic out_pos;
   logic out_neg;
   logic rd_accept;
   logic rd_load;

   // In single clock mode the input pair also times the read data.
   assign out_pos = single_clock_mode_i ? input_edge_pos_i : read_out_edge_pos_i;
   assign out_neg = single_clock_mode_i ? input_edge_neg_i : read_out_edge_neg_i;
   assign rd_accept = input_edge_pos_i && !read_port_sel_n_i &&
      (rd_state_r == qrs_pkg::QRS_RD_IDLE || rd_state_r == qrs_pkg::QRS_RD_HOLD);
   // With the delay loop on, the first beat lands half an output cycle later.
   assign rd_load = (rd_state_r == qrs_pkg::QRS_RD_BURST && (out_pos || out_neg)) ||
      (rd_state_r == qrs_pkg::QRS_RD_WAIT && out_pos && !dll_disable_n_i);

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_state_r <= qrs_pkg::QRS_RD_IDLE;
         rd_beat_r <= `QRS_BEAT_FIRST;
      end else begin
         case (rd_state_r)
            qrs_pkg::QRS_RD_IDLE: begin
               if (rd_accept) begin
                  rd_state_r <= qrs_pkg::QRS_RD_WAIT;
                  rd_beat_r <= `QRS_BEAT_FIRST;
               end
            end
            qrs_pkg::QRS_RD_WAIT: begin
               if (out_pos) begin
                  rd_state_r <= qrs_pkg::QRS_RD_BURST;
                  rd_beat_r <= dll_disable_n_i ? `QRS_BEAT_FIRST : `QRS_BEAT_SECOND;
               end
            end
            qrs_pkg::QRS_RD_BURST: begin
               if (rd_load) begin
                  rd_beat_r <= rd_beat_r + `QRS_BEAT_SECOND;
                  if (rd_beat_r == `QRS_BEAT_LAST) begin
                     rd_state_r <= qrs_pkg::QRS_RD_HOLD;
                  end
               end
            end
            qrs_pkg::QRS_RD_HOLD: begin
               if (rd_accept) begin
                  rd_state_r <= qrs_pkg::QRS_RD_WAIT;
                  rd_beat_r <= `QRS_BEAT_FIRST;
               end else if (out_pos) begin
                  rd_state_r <= qrs_pkg::QRS_RD_IDLE;
               end
            end
            default: begin
               rd_state_r <= qrs_pkg::QRS_RD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rd_accept) begin
         rd_addr_r <= word_loc_i;
      end
   end

   assign mbus.raddr = {rd_addr_r, rd_beat_r};

   // The last beat stays on the bus until the next positive output edge.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         read_out_o <= '0;
         read_out_oe_o <= `QRS_BIT_CLR;
      end else if (rd_load) begin
         read_out_o <= mbus.rdata;
         read_out_oe_o <= `QRS_BIT_SET;
      end else if (rd_state_r == qrs_pkg::QRS_RD_HOLD && out_pos && !rd_accept) begin
         read_out_oe_o <= `QRS_BIT_CLR;
      end
   end

   // ==========================================================
   // Echo strobe
   // ==========================================================
   // Free-running: it follows whichever pair times the read data.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         echo_strobe_o <= `QRS_BIT_CLR;
      end else if (out_pos) begin
         echo_strobe_o <= `QRS_BIT_SET;
      end else if (out_neg) begin
         echo_strobe_o <= `QRS_BIT_CLR;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_wr_go;
      input_edge_pos_i && !write_port_sel_n_i && read_port_sel_n_i && !wr_active_r;
   endsequence
   sequence s_rd_last;
      rd_state_r == qrs_pkg::QRS_RD_BURST && rd_load && rd_beat_r == `QRS_BEAT_LAST;
   endsequence

   a_wr_deselect_idle: assert property (!wr_active_r && write_port_sel_n_i |-> !mbus.we)
      else $error("write data taken while write port deselected");
   a_wr_start_addr: assert property (s_wr_go |-> mbus.we && mbus.waddr == {word_loc_i, `QRS_BEAT_FIRST})
      else $error("write start did not use the sampled address");
   a_wr_lane_mask: assert property (mbus.we |-> mbus.lane_en == ~byte_write_sel_n_i)
      else $error("lane enables do not follow write selects");
   a_rd_start_wait: assert property (rd_accept |=> rd_state_r == qrs_pkg::QRS_RD_WAIT)
      else $error("read select did not start a read");
   a_rd_idle_float: assert property (rd_state_r == qrs_pkg::QRS_RD_IDLE && $past(rd_state_r) ==
      qrs_pkg::QRS_RD_IDLE |-> !read_out_oe_o)
      else $error("read bus driven while idle");
   a_rd_burst_end: assert property (s_rd_last |=> rd_state_r == qrs_pkg::QRS_RD_HOLD && read_out_oe_o)
      else $error("burst did not end after four words");
   a_rd_hold_off: assert property (rd_state_r == qrs_pkg::QRS_RD_HOLD && out_pos && !rd_accept
      |=> !read_out_oe_o && rd_state_r == qrs_pkg::QRS_RD_IDLE)
      else $error("bus not released after the final edge");
   a_dll_off_beat: assert property (rd_state_r == qrs_pkg::QRS_RD_WAIT && out_pos && !dll_disable_n_i
      |=> read_out_oe_o && rd_beat_r == `QRS_BEAT_SECOND)
      else $error("delay-loop-off read did not drive the first beat");
   a_echo_follow: assert property (out_pos |=> echo_strobe_o)
      else $error("echo strobe did not follow the output edge");
endmodule

// File: test/qrs_ctl_model.sv
// Controller model: input and output clock pulses, write bursts and read requests.
`timescale 1ns/1ns
module qrs_ctl_model (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   output logic edge_pos_o,
   output logic edge_neg_o,
   output logic out_pos_o,
   output logic out_neg_o,
   output logic wsel_n_o,
   output logic rsel_n_o,
   output logic [16:0] addr_o,
   output logic [35:0] data_o,
   output logic [3:0] mask_n_o
);
   logic ph_r;

   // ==========================================
   // Clock pulses
   always_ff @(negedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ph_r <= 1'h0;
      end else begin
         ph_r <= ~ph_r;
      end
   end
   assign edge_pos_o = ph_r;
   assign edge_neg_o = ~ph_r;
   assign out_pos_o = ~ph_r;
   assign out_neg_o = ph_r;

   initial begin
      wsel_n_o = 1'h1;
      rsel_n_o = 1'h1;
      addr_o = 17'h00000;
      data_o = 36'h000000000;
      mask_n_o = 4'hF;
   end

   // ==========================================
   // Requests
   // Waits for the falling edge that precedes a positive input pulse.
   task automatic sync_pos();
      do @(negedge sys_clk_i); while (ph_r !== 1'h0);
   endtask

   task automatic wr(input logic sel_n, input logic [16:0] a, input logic [35:0] d[4], input logic [3:0] mk[4]);
      sync_pos();
      wsel_n_o <= sel_n;
      addr_o <= a;
      for (int i = 0; i < 4; i++) begin
         if (i > 0) begin
            @(negedge sys_clk_i);
            wsel_n_o <= 1'h1;
            addr_o <= ~a;
         end
         data_o <= d[i];
         mask_n_o <= mk[i];
      end
      // Released lines show the inverse so stale values cannot pass.
      @(negedge sys_clk_i);
      data_o <= ~d[3];
      mask_n_o <= ~mk[3];
   endtask

   task automatic rd(input logic [16:0] a);
      sync_pos();
      rsel_n_o <= 1'h0;
      addr_o <= a;
      @(negedge sys_clk_i);
      rsel_n_o <= 1'h1;
      addr_o <= ~a;
   endtask
endmodule

// File: test/test_quad_rate_sram_port_signals.sv
// Self-checking bench for the burst SRAM port logic.
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_quad_rate_sram_port_signals;
   logic sys_clk_i = 1'h0;
   logic resetn_i = 1'h0;
   logic single_i = 1'h0;
   logic dll_n_i = 1'h0;
   logic ep, en, op, on, ws, rs, oe, echo;
   logic [16:0] addr;
   logic [35:0] wd, rdat;
   logic [3:0] mk_n;
   logic [35:0] d[4], nd[4], e[4];
   logic [3:0] mk[4];
   logic [7:0] rdat8;
   logic [7:0] d8[4], e8[4];
   logic [3:0] zm[4] = '{4'h0, 4'h0, 4'h0, 4'h0};
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;

   always #5 sys_clk_i = ~sys_clk_i;

   qrs_ctl_model m (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .edge_pos_o(ep), .edge_neg_o(en),
      .out_pos_o(op), .out_neg_o(on), .wsel_n_o(ws), .rsel_n_o(rs), .addr_o(addr), .data_o(wd), .mask_n_o(mk_n));

   qrs_port dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .input_edge_pos_i(ep), .input_edge_neg_i(en),
      .read_out_edge_pos_i(op), .read_out_edge_neg_i(on), .single_clock_mode_i(single_i),
      .dll_disable_n_i(dll_n_i), .write_port_sel_n_i(ws), .read_port_sel_n_i(rs), .word_loc_i(addr),
      .write_in_i(wd), .byte_write_sel_n_i(mk_n), .read_out_o(rdat), .read_out_oe_o(oe), .echo_strobe_o(echo));

   // A second instance in the nibble configuration sees the same stimulus.
   qrs_port #(.DATA_W(8), .LANE_W(4), .ADDR_W(19)) dut_nib (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .input_edge_pos_i(ep), .input_edge_neg_i(en), .read_out_edge_pos_i(op), .read_out_edge_neg_i(on),
      .single_clock_mode_i(single_i), .dll_disable_n_i(dll_n_i), .write_port_sel_n_i(ws),
      .read_port_sel_n_i(rs), .word_loc_i({2'h0, addr}), .write_in_i(wd[7:0]), .byte_write_sel_n_i(mk_n[1:0]),
      .read_out_o(rdat8), .read_out_oe_o(), .echo_strobe_o());

   // ==========================================
   // Shared tasks
   task automatic tally_and_finish();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Reads one burst and checks beats, enable, echo level and the release afterwards.
   task automatic rd_chk(input logic [16:0] a, input logic [35:0] x[4], input logic [7:0] y[4], input logic echo0);
      int n;
      m.rd(a);
      n = 0;
      do begin @(negedge sys_clk_i); n++; end while (oe !== 1'h1 && n < 8);
      for (int i = 0; i < 4; i++) begin
         if (i > 0) @(negedge sys_clk_i);
         `CHK(oe, 1'h1);
         `CHK(rdat, x[i]);
         `CHK(rdat8, y[i]);
         `CHK(echo, echo0 ^ i[0]);
      end
      n = 0;
      do begin @(negedge sys_clk_i); n++; end while (oe !== 1'h0 && n < 4);
      `CHK(oe, 1'h0);
   endtask

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   // ==========================================
   // Scenarios
   initial begin
      repeat (2) @(negedge sys_clk_i);
      // Non-blocking release keeps the model's clock phase free of a race with reset.
      resetn_i <= 1'h1;
      @(negedge sys_clk_i);
      `CHK(oe, 1'h0);
      for (int i = 0; i < 4; i++) begin
         d[i] = 36'hA5C3F0E10 ^ i;
         nd[i] = ~d[i];
         d8[i] = d[i][7:0];
      end
      mk = '{4'h1, 4'h2, 4'h4, 4'hA};
      m.wr(1'h0, 17'h01234, d, zm);
      rd_chk(17'h01234, d, d8, 1'h1);
      m.wr(1'h0, 17'h01234, nd, mk);
      for (int i = 0; i < 4; i++) begin
         for (int g = 0; g < 4; g++) begin
            e[i][g*9+:9] = mk[i][g] ? d[i][g*9+:9] : nd[i][g*9+:9];
         end
         for (int g = 0; g < 2; g++) begin
            e8[i][g*4+:4] = mk[i][g] ? d[i][g*4+:4] : nd[i][g*4+:4];
         end
      end
      rd_chk(17'h01234, e, e8, 1'h1);
      m.wr(1'h1, 17'h01234, d, zm);
      rd_chk(17'h01234, e, e8, 1'h1);
      m.wr(1'h0, 17'h1FFFF, d, zm);
      rd_chk(17'h1FFFF, d, d8, 1'h1);
      rd_chk(17'h01234, e, e8, 1'h1);
      single_i = 1'h1;
      rd_chk(17'h01234, e, e8, 1'h1);
      single_i = 1'h0;
      dll_n_i = 1'h1;
      rd_chk(17'h01234, e, e8, 1'h0);
      tally_and_finish();
   end
endmodule
